// ---- dv/hic_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hic_host_model (
  input wire logic i_pin_o,
  input wire logic i_pin_oe,
  output logic o_pin_level
);
  // host-side pull-up, so a released open-drain pin reads high
  assign o_pin_level = i_pin_oe ? i_pin_o : 1'h1;
endmodule
`default_nettype wire

// ---- dv/hic_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module hic_properties (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic i_src_wake_fifo,
  input wire logic i_src_nonwake_fifo,
  input wire logic i_src_sync_status,
  input wire logic i_src_async_status,
  input wire logic i_src_fault,
  input wire logic i_fw_init_done,
  input wire logic i_warm_reset,
  input wire logic i_warm_keep_cfg,
  input wire logic o_host_irq_pin_o,
  input wire logic o_host_irq_pin_oe
);
  // shadow config from bus writes; st_q gives a new mode time to settle
  logic [7:0] cfg_q, cfg_d;
  logic [1:0] st_q, st_d;
  logic fw_q, fw_d, req;
  assign req = fw_q && |({i_src_fault, i_src_async_status, i_src_sync_status,
    i_src_nonwake_fifo, i_src_wake_fifo} & ~cfg_q[4:0]);
  always_comb begin
    cfg_d = cfg_q;
    st_d = st_q + {1'h0, st_q != 2'h3};
    fw_d = (fw_q || i_fw_init_done) && !i_warm_reset;
    if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 8'h1c && i_pstrb[0]) begin
      cfg_d = i_pwdata[7:0];
      st_d = 2'h0;
    end
    if (i_warm_reset) begin
      st_d = 2'h0;
      cfg_d = i_warm_keep_cfg ? cfg_q : 8'h00;
    end
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_q <= 8'h00;
      st_q <= 2'h0;
      fw_q <= 1'h0;
    end else begin
      cfg_q <= cfg_d;
      st_q <= st_d;
      fw_q <= fw_d;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_pready_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready late");
  a_pready_once: assert property (o_pready |=> !o_pready)
    else $error("pready held");
  a_err_map: assert property (o_pready && i_psel |->
    o_pslverr == !(i_paddr inside {8'h1c, 8'h20, 8'h24, 8'h28})) else $error("bad pslverr");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr alone");
  a_upper_zero: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_level_track: assert property (st_q == 2'h3 && cfg_q[7:6] == 2'h0 |->
    o_host_irq_pin_o == ($past(req, 2) ^ cfg_q[5])) else $error("level pin wrong");
  a_od_track: assert property (st_q == 2'h3 && cfg_q[7:6] == 2'h2 |->
    !o_host_irq_pin_o && o_host_irq_pin_oe == !($past(req, 2) ^ cfg_q[5]))
    else $error("open drain pin wrong");
  a_pulse_start: assert property (st_q == 2'h3 && cfg_q[7:5] == 3'h2 && $past(req, 2) &&
    !$past(req, 3) |-> ##[0:2] o_host_irq_pin_o) else $error("pulse missing");
endmodule
`default_nettype wire

// ---- dv/host_interrupt_control_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_interrupt_control_bench;
  logic i_clk = 1'h0, i_resetn = 1'h0, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  wire logic [3:0] i_pstrb = 4'hf;
  logic [4:0] src = 5'h00;
  wire logic i_src_wake_fifo = src[0];
  wire logic i_src_nonwake_fifo = src[1];
  wire logic i_src_sync_status = src[2];
  wire logic i_src_async_status = src[3];
  wire logic i_src_fault = src[4];
  logic i_fw_init_done = 1'h0, i_warm_reset = 1'h0, i_warm_keep_cfg = 1'h0;
  wire logic i_host_irq_pin_i;
  logic o_pready, o_pslverr, o_host_irq_pin_o, o_host_irq_pin_oe, o_irq, err, lv, od;
  logic [31:0] o_prdata, rd;
  logic [7:0] modes [3] = '{8'h20, 8'h80, 8'ha0};
  int miscompares = 0;
  int checks = 0;
  int pw;
  hic_top u_dut (.*);
  hic_host_model u_host (
    .i_pin_o(o_host_irq_pin_o),
    .i_pin_oe(o_host_irq_pin_oe),
    .o_pin_level(i_host_irq_pin_i)
  );
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo();
    miscompares++;
    $display("wrong value at %0t: wait ran out", $time);
    results();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'h1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'h1 && n < 20);
    if (n >= 20) tmo();
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  task automatic warm(input logic k);
    i_warm_keep_cfg <= k;
    i_warm_reset <= 1'h1;
    cyc(1);
    i_warm_reset <= 1'h0;
  endtask
  initial begin
    cyc(6);
    i_resetn <= 1'h1;
    cyc(2);
    chk(o_host_irq_pin_oe, 1'h1);
    xfer(1'h0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    xfer(1'h1, 8'h1c, 32'h5a);
    xfer(1'h0, 8'h1c, 32'h0);
    chk(rd, 32'h5a);
    xfer(1'h0, 8'h40, 32'h0);
    chk(err, 1'h1);
    xfer(1'h0, 8'h1d, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'h1);
    xfer(1'h1, 8'h1c, 32'h0);
    src <= 5'h1f;
    cyc(4);
    chk(o_host_irq_pin_o, 1'h0);
    src <= 5'h00;
    i_fw_init_done <= 1'h1;
    cyc(1);
    i_fw_init_done <= 1'h0;
    pw = 0;
    do begin
      xfer(1'h0, 8'h28, 32'h0);
      pw++;
    end while (rd[1] !== 1'h1 && pw < 8);
    if (rd[1] !== 1'h1) tmo();
    chk(rd, 32'h2);
    $display("test boot done");
    for (int i = 0; i < 5; i++) begin
      xfer(1'h1, 8'h1c, 1 << i);
      src <= 5'(1 << i);
      cyc(3);
      chk(o_host_irq_pin_o, 1'h0);
      xfer(1'h1, 8'h1c, 32'h1f ^ (1 << i));
      cyc(3);
      chk(o_host_irq_pin_o, 1'h1);
      src <= 5'h00;
      cyc(3);
      chk(o_host_irq_pin_o, 1'h0);
    end
    $display("test masks done");
    foreach (modes[j]) begin
      xfer(1'h1, 8'h1c, {24'h0, modes[j]});
      for (int a = 1; a >= 0; a--) begin
        src <= {4'h0, a[0]};
        cyc(3);
        lv = a[0] ^ modes[j][5];
        od = modes[j][7];
        chk({o_host_irq_pin_oe, o_host_irq_pin_o, i_host_irq_pin_i},
          {od ? ~lv : 1'h1, od ? 1'h0 : lv, lv});
      end
    end
    $display("test drive done");
    xfer(1'h1, 8'h1c, 32'h40);
    cyc(3);
    src <= 5'h01;
    pw = 0;
    while (o_host_irq_pin_o !== 1'h1 && pw < 20) begin
      @(posedge i_clk);
      pw++;
    end
    if (pw >= 20) tmo();
    pw = 0;
    while (o_host_irq_pin_o === 1'h1 && pw < 600) begin
      @(posedge i_clk);
      pw++;
    end
    chk(pw, 500);
    src <= 5'h00;
    xfer(1'h0, 8'h20, 32'h0);
    $display("test pulse done");
    xfer(1'h1, 8'h24, 32'h1);
    src <= 5'h01;
    cyc(3);
    chk(o_irq, 1'h1);
    xfer(1'h0, 8'h20, 32'h0);
    chk(rd, 32'h21);
    cyc(2);
    chk(o_irq, 1'h0);
    src <= 5'h00;
    xfer(1'h1, 8'h24, 32'h0);
    src <= 5'h01;
    cyc(3);
    chk(o_irq, 1'h0);
    src <= 5'h00;
    $display("test events done");
    xfer(1'h1, 8'h1c, 32'h20);
    warm(1'h1);
    xfer(1'h0, 8'h1c, 32'h0);
    chk(rd, 32'h20);
    src <= 5'h01;
    cyc(4);
    chk(o_host_irq_pin_o, 1'h1);
    src <= 5'h00;
    warm(1'h0);
    xfer(1'h0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    $display("test warm done");
    results();
  end
endmodule
bind hic_top hic_properties u_chk (.*);
`default_nettype wire

// ---- hw/hic_pkg.sv ----
package hic_pkg;
  localparam int unsigned hic_clk_period_ns = 20;
  localparam int unsigned hic_pulse_time_us = 10;
  // longest-time rounding: floor, but never below one cycle
  localparam int unsigned hic_pulse_cyc_raw = (hic_pulse_time_us * 1000) / hic_clk_period_ns;
  localparam int unsigned hic_pulse_cycles = (hic_pulse_cyc_raw < 1) ? 1 : hic_pulse_cyc_raw;
  localparam int unsigned hic_pulse_cnt_w = $clog2(hic_pulse_cycles + 1);

  localparam int unsigned hic_addr_w = 8;
  localparam int unsigned hic_data_w = 32;
  localparam int unsigned hic_nsrc = 5;
  localparam int unsigned hic_nevt = 6;

  // register indices; byte address is four times the index
  localparam logic [hic_addr_w-1:0] hic_idx_cfg = 8'h07;
  localparam logic [hic_addr_w-1:0] hic_idx_evt_status = 8'h08;
  localparam logic [hic_addr_w-1:0] hic_idx_evt_mask = 8'h09;
  localparam logic [hic_addr_w-1:0] hic_idx_state = 8'h0a;

  // host_irq_config field positions
  localparam int unsigned hic_cfg_mask_lsb = 0;
  localparam int unsigned hic_cfg_active_low = 5;
  localparam int unsigned hic_cfg_pulse_mode = 6;
  localparam int unsigned hic_cfg_open_drain = 7;
  localparam logic [7:0] hic_cfg_reset = 8'h00;
  localparam logic [hic_nevt-1:0] hic_evt_mask_reset = 6'h00;

  // event status bits 0..4 follow the source order; bit 5 is pin assertion
  localparam int unsigned hic_evt_pin = 5;

  // state register bit positions
  localparam int unsigned hic_st_req = 0;
  localparam int unsigned hic_st_fw_ready = 1;
  localparam int unsigned hic_st_pulse_busy = 2;
  localparam int unsigned hic_st_pin_level = 3;
endpackage

// ---- hw/hic_pulse_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module hic_pulse_timer
  import hic_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_clear,
  output logic o_busy
);
  logic [hic_pulse_cnt_w-1:0] cnt_q;
  logic [hic_pulse_cnt_w-1:0] cnt_d;
  logic busy_q;
  logic busy_d;

  // a start while busy restarts the full width
  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy_q;
    if (i_clear) begin
      cnt_d = '0;
      busy_d = 1'b0;
    end else if (i_start) begin
      cnt_d = hic_pulse_cnt_w'(hic_pulse_cycles - 1);
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
    end
  end

  assign o_busy = busy_q;
endmodule
`default_nettype wire

// ---- hw/hic_sync3.sv ----
`timescale 1ns/1ps
`default_nettype none
module hic_sync3 (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_async,
  output logic o_level
);
  logic [2:0] ff_q;
  logic [2:0] ff_d;
  logic level_q;
  logic level_d;

  // level only moves when the second and third stages agree
  always_comb begin
    ff_d = {ff_q[1:0], i_async};
    level_d = (ff_q[1] == ff_q[2]) ? ff_q[2] : level_q;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ff_q <= 3'h0;
      level_q <= 1'h0;
    end else begin
      ff_q <= ff_d;
      level_q <= level_d;
    end
  end

  assign o_level = level_q;
endmodule
`default_nettype wire

// ---- hw/hic_top.sv ----
// Summary of operation
// - configuration register at index 0x07 is read-write, reads return last write.
// - host interrupt stays deasserted until firmware initialisation completes.
// - watchdog or fatal warm reset keeps the configuration register contents.
// - during boot stage no host interrupt of any kind is raised.
// - configuration may change anytime; later interrupts use the new mode.
// - configuration resets to zero: active high, level, push-pull, unmasked.
// - after firmware initialisation, interrupt is asserted using the current mode.
// - bit 0 set masks wake-up FIFO interrupts.
// - bit 1 set masks non-wake-up FIFO interrupts.
// - bit 2 set masks synchronous status available interrupts.
// - bit 3 set masks asynchronous status or debug interrupts.
// - bit 4 set masks fault interrupts.
// - bit 5 selects polarity: 0 active high, 1 active low.
// - bit 6 selects level until cause clears, or one 10 us pulse.
// - bit 7 selects push-pull at 0 or open-drain at 1.
`timescale 1ns/1ps
`default_nettype none
module hic_top
  import hic_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [hic_addr_w-1:0] i_paddr,
  input wire logic [hic_data_w-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [hic_data_w-1:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_src_wake_fifo,
  input wire logic i_src_nonwake_fifo,
  input wire logic i_src_sync_status,
  input wire logic i_src_async_status,
  input wire logic i_src_fault,
  input wire logic i_fw_init_done,
  input wire logic i_warm_reset,
  input wire logic i_warm_keep_cfg,
  input wire logic i_host_irq_pin_i,
  output logic o_host_irq_pin_o,
  output logic o_host_irq_pin_oe,
  output logic o_irq
);
  // bus slave
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [hic_data_w-1:0] prdata_q;
  logic [hic_data_w-1:0] prdata_d;
  logic access;
  logic done;
  logic wr_en;
  logic rd_done;
  logic addr_ok;
  logic [hic_addr_w-1:0] idx;
  logic hit_cfg;
  logic hit_evt_status;
  logic hit_evt_mask;
  logic hit_state;
  logic cfg_wr;
  logic mask_wr;
  logic status_clr;

  // registers
  logic [7:0] cfg_q;
  logic [7:0] cfg_d;
  logic [hic_nevt-1:0] evt_q;
  logic [hic_nevt-1:0] evt_d;
  logic [hic_nevt-1:0] evt_mask_q;
  logic [hic_nevt-1:0] evt_mask_d;
  logic [hic_nevt-1:0] evt_seen_q;
  logic [hic_nevt-1:0] evt_seen_d;

  // core state
  logic fw_ready_q;
  logic fw_ready_d;
  logic req_q;
  logic req_d;
  logic [hic_nsrc-1:0] src_q;
  logic [hic_nsrc-1:0] src_now;
  logic assert_now;
  logic pin_o_q;
  logic pin_o_d;
  logic pin_oe_q;
  logic pin_oe_d;
  logic irq_q;
  logic irq_d;
  logic pulse_busy;
  logic pulse_start;
  logic pin_level;
  logic assert_q;
  logic assert_d;
  logic [hic_nsrc-1:0] src_d;

  function automatic logic [hic_data_w-1:0] zext8(input logic [7:0] v);
    zext8 = {{(hic_data_w-8){1'b0}}, v};
  endfunction

  // misaligned addresses hit nothing, so they answer with an error
  function automatic logic reg_hit(input logic [hic_addr_w-1:0] a,
                                   input logic [hic_addr_w-1:0] t);
    reg_hit = (a[1:0] == 2'h0) && ({2'h0, a[hic_addr_w-1:2]} == t);
  endfunction

  assign src_now = {i_src_fault, i_src_async_status, i_src_sync_status,
                    i_src_nonwake_fifo, i_src_wake_fifo};

  // word-aligned decode; low address bits must be zero
  assign idx = {2'h0, i_paddr[hic_addr_w-1:2]};
  assign access = i_psel && i_penable;
  assign done = access && pready_q;
  assign wr_en = done && i_pwrite && !pslverr_q;
  assign rd_done = done && !i_pwrite && !pslverr_q;
  assign hit_cfg = reg_hit(i_paddr, hic_idx_cfg);
  assign hit_evt_status = reg_hit(i_paddr, hic_idx_evt_status);
  assign hit_evt_mask = reg_hit(i_paddr, hic_idx_evt_mask);
  assign hit_state = reg_hit(i_paddr, hic_idx_state);
  assign addr_ok = hit_cfg || hit_evt_status || hit_evt_mask || hit_state;
  assign cfg_wr = wr_en && hit_cfg && i_pstrb[0];
  assign mask_wr = wr_en && hit_evt_mask && i_pstrb[0];
  assign status_clr = rd_done && hit_evt_status;

  // one wait state so that ready and read data both leave flip-flops
  always_comb begin
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    evt_seen_d = evt_seen_q;
    if (access && !pready_q) begin
      pready_d = 1'b1;
      pslverr_d = !addr_ok;
      prdata_d = '0;
      evt_seen_d = '0;
      // refused reads return zero
      if (!i_pwrite && addr_ok) begin
        case (idx)
          hic_idx_cfg: prdata_d = zext8(cfg_q);
          hic_idx_evt_status: begin
            prdata_d = zext8({2'h0, evt_q});
            evt_seen_d = evt_q;
          end
          hic_idx_evt_mask: prdata_d = zext8({2'h0, evt_mask_q});
          hic_idx_state: begin
            prdata_d[hic_st_req] = req_q;
            prdata_d[hic_st_fw_ready] = fw_ready_q;
            prdata_d[hic_st_pulse_busy] = pulse_busy;
            prdata_d[hic_st_pin_level] = pin_level;
          end
          default: prdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      evt_seen_q <= '0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      evt_seen_q <= evt_seen_d;
    end
  end

  // register file
  always_comb begin
    cfg_d = cfg_q;
    evt_mask_d = evt_mask_q;
    // warm reset of the watchdog or fatal kind leaves the configuration alone
    if (i_warm_reset && !i_warm_keep_cfg) begin
      cfg_d = hic_cfg_reset;
    end else if (cfg_wr) begin
      cfg_d = i_pwdata[7:0];
    end
    if (mask_wr) begin
      evt_mask_d = i_pwdata[hic_nevt-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_q <= hic_cfg_reset;
      evt_mask_q <= hic_evt_mask_reset;
    end else begin
      cfg_q <= cfg_d;
      evt_mask_q <= evt_mask_d;
    end
  end

  // request and boot gating
  always_comb begin
    fw_ready_d = fw_ready_q;
    // warm reset outranks an init strobe in the same cycle
    if (i_warm_reset) begin
      fw_ready_d = 1'b0;
    end else if (i_fw_init_done) begin
      fw_ready_d = 1'b1;
    end
    // masked sources never reach the request
    req_d = fw_ready_q &&
            (|(src_now &
               ~cfg_q[hic_cfg_mask_lsb +: hic_nsrc]));
    // previous levels, kept for edge capture
    src_d = src_now;
    assert_d = assert_now;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fw_ready_q <= 1'b0;
      req_q <= 1'b0;
      src_q <= '0;
      assert_q <= 1'b0;
    end else begin
      fw_ready_q <= fw_ready_d;
      req_q <= req_d;
      src_q <= src_d;
      assert_q <= assert_d;
    end
  end

  // pulse on each new request; a request held high gives one pulse only
  assign pulse_start = cfg_q[hic_cfg_pulse_mode] && req_d && !req_q;

  hic_pulse_timer u_pulse (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(pulse_start),
    .i_clear(!fw_ready_q || !cfg_q[hic_cfg_pulse_mode]),
    .o_busy(pulse_busy)
  );

  hic_sync3 u_pin_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_async(i_host_irq_pin_i),
    .o_level(pin_level)
  );

  // pin drive
  assign assert_now = cfg_q[hic_cfg_pulse_mode] ? pulse_busy : req_q;

  always_comb begin
    logic lvl;
    lvl = assert_now ^ cfg_q[hic_cfg_active_low];
    if (cfg_q[hic_cfg_open_drain]) begin
      // open drain only ever pulls low; high comes from the pull-up
      pin_o_d = 1'b0;
      pin_oe_d = !lvl;
    end else begin
      pin_o_d = lvl;
      pin_oe_d = 1'b1;
    end
  end

  // local event interrupt
  always_comb begin
    // read clears only what was reported, and a new event wins over the clear
    evt_d = evt_q;
    if (status_clr) begin
      evt_d = evt_q & ~evt_seen_q;
    end
    evt_d[hic_nsrc-1:0] = evt_d[hic_nsrc-1:0] | (src_now & ~src_q);
    evt_d[hic_evt_pin] = evt_d[hic_evt_pin] | (assert_now && !assert_q);
    irq_d = |(evt_d & evt_mask_d);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      evt_q <= '0;
      irq_q <= 1'b0;
    end else begin
      evt_q <= evt_d;
      irq_q <= irq_d;
    end
  end

  // pad drive leaves flip-flops so decode glitches never reach the pin
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign o_pready = pready_q;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;
  assign o_host_irq_pin_o = pin_o_q;
  assign o_host_irq_pin_oe = pin_oe_q;
  assign o_irq = irq_q;
endmodule
`default_nettype wire
